/* shared/vmon_pkg.sv */
// Constants, register map and field layout of the voltage monitor register bank
package vmon_pkg;
    localparam int NUM_CH = 11;
    // Word indexes; byte address is four times the index
    localparam logic [3:0] IDX_EVT_LO   = 4'h0;
    localparam logic [3:0] IDX_EVT_HI   = 4'h1;
    localparam logic [3:0] IDX_SMI_LO   = 4'h2;
    localparam logic [3:0] IDX_SMI_HI   = 4'h3;
    localparam logic [3:0] IDX_IRQ_LO   = 4'h4;
    localparam logic [3:0] IDX_IRQ_HI   = 4'h5;
    localparam logic [3:0] IDX_SUPPLY   = 4'h6;
    localparam logic [3:0] IDX_RATE     = 4'h7;
    localparam logic [3:0] IDX_CONFIG   = 4'h8;
    localparam logic [3:0] IDX_BANK     = 4'h9;
    localparam logic [3:0] IDX_CH_CFG   = 4'ha;
    localparam logic [3:0] IDX_CH_READ  = 4'hb;
    localparam logic [3:0] IDX_CH_HIGH  = 4'hc;
    localparam logic [3:0] IDX_CH_LOW   = 4'hd;
    // Reset values
    localparam logic [7:0] RST_MASK     = 8'h00;
    localparam logic [1:0] RST_CPU_SEL  = 2'h0;
    localparam logic [7:0] RST_RATE     = 8'h00;
    localparam logic [7:0] RST_CONFIG   = 8'h00;
    localparam logic [3:0] RST_BANK     = 4'h0;
    localparam logic [7:0] RST_CH_CFG   = 8'h00;
    localparam logic [7:0] RST_HIGH     = 8'hff;
    localparam logic [7:0] RST_LOW      = 8'h00;
    localparam logic [7:0] RST_READING  = 8'h00;
    // Field layout
    localparam int SUPPLY_CODE_W = 5;
    localparam int CPU_SEL_LSB  = 6;
    localparam logic [7:0] RATE_MASK    = 8'h3f;
    localparam logic [7:0] HI_EVT_MASK  = 8'h07;
    localparam int CFG_CH_EN    = 0;
    localparam int CFG_ALARM_EN = 1;
    localparam int CFG_LOW_HIT  = 5;
    localparam int CFG_HIGH_HIT = 6;
    localparam logic [7:0] CH_CFG_RW    = 8'h03;
endpackage

/* hw/input_sync.sv */
// Three-stage pin synchroniser that accepts a change once two stages agree
`timescale 1ns/1ps
module input_sync #(
    parameter int W = 5
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Pin side and clean side
    input  wire logic [W-1:0] din,
    output      logic [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Output moves only when the later stages agree
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dout <= '0;
        end else if (s2_r == s3_r) begin
            dout <= s3_r;
        end
    end
endmodule

/* hw/voltage_monitor_event_regs.sv */
// Register bank of the voltage level monitor with event status and interrupt routing
`timescale 1ns/1ps
module voltage_monitor_event_regs
    import vmon_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [5:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output      logic [31:0]       wb_dat_o,
    output      logic              wb_ack_o,
    // Converter results
    input  wire logic              sample_valid,
    input  wire logic [3:0]        sample_channel,
    input  wire logic [7:0]        sample_value,
    // Supply code pins
    input  wire logic [SUPPLY_CODE_W-1:0] supply_code_cpu0,
    input  wire logic [SUPPLY_CODE_W-1:0] supply_code_cpu1,
    // Interrupts and alarm
    output      logic              mgmt_irq,
    output      logic              host_irq,
    output      logic              alarm_out,
    // Settings for the converter
    output      logic [5:0]        conversion_rate_out,
    output      logic [7:0]        monitor_config_out,
    output      logic [NUM_CH-1:0] channel_enable_out
);
    logic              ack_r;
    logic [NUM_CH-1:0] event_r;
    logic [NUM_CH-1:0] event_nxt;
    logic [7:0]        smi_lo_r;
    logic [7:0]        smi_hi_r;
    logic [7:0]        irq_lo_r;
    logic [7:0]        irq_hi_r;
    logic [1:0]        cpu_sel_r;
    logic [7:0]        rate_r;
    logic [7:0]        config_r;
    logic [3:0]        bank_r;
    logic [7:0]        ch_cfg_r  [NUM_CH];
    logic [7:0]        reading_r [NUM_CH];
    logic [7:0]        high_r    [NUM_CH];
    logic [7:0]        low_r     [NUM_CH];
    logic [NUM_CH-1:0] hit_vec;
    logic [NUM_CH-1:0] alarm_en_vec;
    logic [NUM_CH-1:0] smi_vec;
    logic [NUM_CH-1:0] irq_vec;
    logic [SUPPLY_CODE_W-1:0] code0_s;
    logic [SUPPLY_CODE_W-1:0] code1_s;
    logic [7:0]        read_data;
    logic [NUM_CH-1:0] rd_clear;
    logic              bank_ok;
    logic              rd_take;
    logic [3:0]        idx;

    assign idx     = wb_adr_i[5:2];
    assign bank_ok = (bank_r < 4'(NUM_CH));
    assign rd_take = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;

    // Write strobe at the ack edge with the low byte lane enabled
    function automatic logic wr_hit(input logic [3:0] target);
        wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0] && (idx == target);
    endfunction

    // Read completion at the ack edge
    function automatic logic rd_done(input logic [3:0] target);
        rd_done = wb_cyc_i && wb_stb_i && !wb_we_i && ack_r && (idx == target);
    endfunction

    // Pin synchronisers for both supply code inputs
    input_sync #(.W(SUPPLY_CODE_W)) u_sync_code0 (
        .clock (clock),
        .rst   (rst),
        .din   (supply_code_cpu0),
        .dout  (code0_s)
    );
    input_sync #(.W(SUPPLY_CODE_W)) u_sync_code1 (
        .clock (clock),
        .rst   (rst),
        .din   (supply_code_cpu1),
        .dout  (code1_s)
    );

    // Per-channel flag vectors
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            hit_vec[i]            = ch_cfg_r[i][CFG_HIGH_HIT] | ch_cfg_r[i][CFG_LOW_HIT];
            alarm_en_vec[i]       = ch_cfg_r[i][CFG_ALARM_EN];
            channel_enable_out[i] = ch_cfg_r[i][CFG_CH_EN];
        end
    end

    // Mask vectors laid out like the status vector
    assign smi_vec = {smi_hi_r[2:0], smi_lo_r};
    assign irq_vec = {irq_hi_r[2:0], irq_lo_r};

    // Wishbone ack, one cycle per request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end
    assign wb_ack_o = ack_r;

    // Read data mux
    // common register decode
    always_comb begin
        read_data = 8'h00;
        unique case (idx)
            IDX_EVT_LO:  read_data = event_r[7:0];
            IDX_EVT_HI:  read_data = {5'h00, event_r[NUM_CH-1:8]};
            IDX_SMI_LO:  read_data = smi_lo_r;
            IDX_SMI_HI:  read_data = smi_hi_r & HI_EVT_MASK;
            IDX_IRQ_LO:  read_data = irq_lo_r;
            IDX_IRQ_HI:  read_data = irq_hi_r & HI_EVT_MASK;
            IDX_SUPPLY:  read_data = {cpu_sel_r, 1'b0,
                                      (cpu_sel_r == 2'h0) ? code0_s :
                                      (cpu_sel_r == 2'h1) ? code1_s : 5'h00};
            IDX_RATE:    read_data = rate_r;
            IDX_CONFIG:  read_data = config_r;
            IDX_BANK:    read_data = {4'h0, bank_r};
            IDX_CH_CFG:  read_data = bank_ok ? ch_cfg_r[bank_r]  : 8'h00;
            IDX_CH_READ: read_data = bank_ok ? reading_r[bank_r] : 8'h00;
            IDX_CH_HIGH: read_data = bank_ok ? high_r[bank_r]    : 8'h00;
            IDX_CH_LOW:  read_data = bank_ok ? low_r[bank_r]     : 8'h00;
            default:     read_data = 8'h00;
        endcase
    end

    // Registered read data, captured as the ack is raised
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_take) begin
            wb_dat_o <= {24'h00_0000, read_data};
        end
    end

    // Read clears of the status registers
    always_comb begin
        rd_clear = '0;
        if (rd_done(IDX_EVT_LO)) begin
            rd_clear[7:0] = 8'hff;
        end
        if (rd_done(IDX_EVT_HI)) begin
            rd_clear[NUM_CH-1:8] = 3'h7;
        end
    end

    // Sticky event status; a hit flag wins over a read clear
    // limit flags set status
    assign event_nxt = (event_r & ~rd_clear) | hit_vec;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_r <= '0;
        end else begin
            event_r <= event_nxt;
        end
    end

    // Management and host interrupt levels, alarm output
    // masked status onto management interrupt
    assign mgmt_irq  = |(event_r & smi_vec);
    assign host_irq  = |(event_r & irq_vec);
    assign alarm_out = |(hit_vec & alarm_en_vec);

    // Interrupt routing masks
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            smi_lo_r <= RST_MASK;
            smi_hi_r <= RST_MASK;
            irq_lo_r <= RST_MASK;
            irq_hi_r <= RST_MASK;
        end else begin
            if (wr_hit(IDX_SMI_LO)) begin
                smi_lo_r <= wb_dat_i[7:0];
            end
            if (wr_hit(IDX_SMI_HI)) begin
                smi_hi_r <= wb_dat_i[7:0] & HI_EVT_MASK;
            end
            if (wr_hit(IDX_IRQ_LO)) begin
                irq_lo_r <= wb_dat_i[7:0];
            end
            if (wr_hit(IDX_IRQ_HI)) begin
                irq_hi_r <= wb_dat_i[7:0] & HI_EVT_MASK;
            end
        end
    end

    // Common settings: supply code select, rate, config, bank
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_sel_r <= RST_CPU_SEL;
            rate_r    <= RST_RATE;
            config_r  <= RST_CONFIG;
            bank_r    <= RST_BANK;
        end else begin
            if (wr_hit(IDX_SUPPLY)) begin
                cpu_sel_r <= wb_dat_i[CPU_SEL_LSB +: 2];
            end
            if (wr_hit(IDX_RATE)) begin
                rate_r <= wb_dat_i[7:0] & RATE_MASK;
            end
            if (wr_hit(IDX_CONFIG)) begin
                config_r <= wb_dat_i[7:0];
            end
            if (wr_hit(IDX_BANK)) begin
                bank_r <= wb_dat_i[3:0];
            end
        end
    end
    assign conversion_rate_out = rate_r[5:0];
    assign monitor_config_out  = config_r;

    // Banked channel registers; new hits win over write-one-to-clear
    // per-channel register set
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ch_cfg_r[i]  <= RST_CH_CFG;
                reading_r[i] <= RST_READING;
                high_r[i]    <= RST_HIGH;
                low_r[i]     <= RST_LOW;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (bank_ok && bank_r == 4'(i) && wr_hit(IDX_CH_CFG)) begin
                    ch_cfg_r[i] <= (ch_cfg_r[i] & ~CH_CFG_RW & ~wb_dat_i[7:0])
                                   | (wb_dat_i[7:0] & CH_CFG_RW);
                end
                if (bank_ok && bank_r == 4'(i) && wr_hit(IDX_CH_HIGH)) begin
                    high_r[i] <= wb_dat_i[7:0];
                end
                if (bank_ok && bank_r == 4'(i) && wr_hit(IDX_CH_LOW)) begin
                    low_r[i] <= wb_dat_i[7:0];
                end
                if (sample_valid && sample_channel == 4'(i)) begin
                    reading_r[i] <= sample_value;
                    if (sample_value > high_r[i]) begin
                        ch_cfg_r[i][CFG_HIGH_HIT] <= 1'b1;
                    end
                    if (sample_value < low_r[i]) begin
                        ch_cfg_r[i][CFG_LOW_HIT] <= 1'b1;
                    end
                end
            end
        end
    end

    // Bus request shapes used by the checks below
    sequence s_write(logic [3:0] target);
        wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0] && idx == target;
    endsequence
    sequence s_read_start(logic [3:0] target);
        rd_take && idx == target;
    endsequence
    sequence s_read_ack(logic [3:0] target);
        wb_cyc_i && wb_stb_i && !wb_we_i && ack_r && idx == target;
    endsequence

    // Ack lasts exactly one cycle
    a_ack_single_pulse: assert property (@(posedge clock) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // Every request is answered in the next cycle
    a_ack_follows_request: assert property (@(posedge clock) disable iff (rst)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");

    a_mask_write_store: assert property (@(posedge clock) disable iff (rst)
        s_write(IDX_SMI_LO) |=> smi_lo_r == $past(wb_dat_i[7:0]))
        else $error("low management mask write not stored");

    a_mask_hi_reserved: assert property (@(posedge clock) disable iff (rst)
        s_write(IDX_SMI_HI) |=> smi_hi_r == ($past(wb_dat_i[7:0]) & HI_EVT_MASK))
        else $error("high management mask write wrong");

    a_bank_write_store: assert property (@(posedge clock) disable iff (rst)
        s_write(IDX_BANK) |=> bank_r == $past(wb_dat_i[3:0]))
        else $error("bank select write not stored");

    a_status_read_clear: assert property (@(posedge clock) disable iff (rst)
        s_read_ack(IDX_EVT_LO) ##0 hit_vec[7:0] == 8'h00 |=> event_r[7:0] == 8'h00)
        else $error("low status not cleared by read");

    a_rate_write_store: assert property (@(posedge clock) disable iff (rst)
        s_write(IDX_RATE) |=> rate_r == ($past(wb_dat_i[7:0]) & RATE_MASK))
        else $error("conversion rate write not stored");

    a_reserved_reads_zero: assert property (@(posedge clock) disable iff (rst)
        rd_take && idx >= 4'he |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("reserved offset read not zero");

    a_hi_status_reserved: assert property (@(posedge clock) disable iff (rst)
        s_read_start(IDX_EVT_HI) |=> wb_dat_o[31:3] == 29'h0 && wb_dat_o[2:0] == $past(event_r[10:8]))
        else $error("high status layout wrong");

    a_lo_status_read: assert property (@(posedge clock) disable iff (rst)
        s_read_start(IDX_EVT_LO) |=> wb_dat_o[7:0] == $past(event_r[7:0]))
        else $error("low status read mismatch");

    a_status_write_ignored: assert property (@(posedge clock) disable iff (rst)
        s_write(IDX_EVT_LO) |=> event_r == ($past(event_r) | $past(hit_vec)))
        else $error("status changed by host write");

    a_hit_sets_status: assert property (@(posedge clock) disable iff (rst)
        (hit_vec & ~event_r) != '0 |=> ($past(hit_vec) & ~event_r) == '0)
        else $error("hit flag did not set status");

    a_mgmt_irq_follow: assert property (@(posedge clock) disable iff (rst)
        (hit_vec & smi_vec) != '0 && !(wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0]
        && (idx == IDX_SMI_LO || idx == IDX_SMI_HI)) |=> mgmt_irq)
        else $error("management interrupt not raised");

    a_masks_after_reset: assert property (@(posedge clock)
        $fell(rst) |-> smi_lo_r == RST_MASK && smi_hi_r == RST_MASK && bank_r == RST_BANK)
        else $error("masks or bank not at reset value");

    a_bank_window_read: assert property (@(posedge clock) disable iff (rst)
        s_read_start(IDX_CH_READ) ##0 bank_ok |=> wb_dat_o[7:0] == $past(reading_r[bank_r]))
        else $error("bank window shows wrong channel");

    a_high_limit_hit: assert property (@(posedge clock) disable iff (rst)
        sample_valid && sample_channel < 4'(NUM_CH) && sample_value > high_r[sample_channel]
        |=> ch_cfg_r[$past(sample_channel)][CFG_HIGH_HIT])
        else $error("high limit hit flag not set");
endmodule

/* bench/voltage_monitor_event_regs_tb_top.sv */
// Self-checking bench of the voltage monitor register bank
`timescale 1ns/1ps
module voltage_monitor_event_regs_tb_top;
    import vmon_pkg::*;
    logic              clock;
    logic              rst;
    logic              wb_cyc_i;
    logic              wb_stb_i;
    logic              wb_we_i;
    logic [5:0]        wb_adr_i;
    logic [3:0]        wb_sel_i;
    logic [31:0]       wb_dat_i;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o;
    logic              sample_valid;
    logic [3:0]        sample_channel;
    logic [7:0]        sample_value;
    logic [SUPPLY_CODE_W-1:0] supply_code_cpu0;
    logic [SUPPLY_CODE_W-1:0] supply_code_cpu1;
    logic              mgmt_irq;
    logic              host_irq;
    logic              alarm_out;
    logic [5:0]        conversion_rate_out;
    logic [7:0]        monitor_config_out;
    logic [NUM_CH-1:0] channel_enable_out;
    int                failures;
    int                checks_done;
    int                cycles;
    logic [7:0]        exp_q[$];
    logic [7:0]        rst_tab[16];
    logic [10:0]       ev;
    logic [7:0]        v;
    logic [7:0]        cf;

    voltage_monitor_event_regs uut (
        .clock(clock), .rst(rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sample_valid(sample_valid), .sample_channel(sample_channel),
        .sample_value(sample_value), .supply_code_cpu0(supply_code_cpu0),
        .supply_code_cpu1(supply_code_cpu1),
        .mgmt_irq(mgmt_irq), .host_irq(host_irq), .alarm_out(alarm_out),
        .conversion_rate_out(conversion_rate_out),
        .monitor_config_out(monitor_config_out),
        .channel_enable_out(channel_enable_out)
    );

    // Free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Verdict and end of run
    task automatic print_verdict();
        $display("Checks made %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Single comparison point
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    // Read data compared against oldest note at each read ack
    always @(posedge clock) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && wb_cyc_i === 1'b1) begin
            if (exp_q.size() > 0) begin
                check(wb_dat_o, {24'h0, exp_q.pop_front()});
            end else begin
                failures++;
                $display("MISMATCH t=%0t unexpected read ack", $time);
            end
        end
    end

    // Classic Wishbone single cycle, held until ack is sampled
    task automatic wb_cycle(input logic we, input logic [3:0] idx, input logic [7:0] d,
                            input logic [3:0] sel);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, d};
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wb_write(input logic [3:0] idx, input logic [7:0] d);
        wb_cycle(1'b1, idx, d, 4'h1);
    endtask

    task automatic wb_read(input logic [3:0] idx, input logic [7:0] exp);
        exp_q.push_back(exp);
        wb_cycle(1'b0, idx, 8'h00, 4'h1);
    endtask

    // One converter result pulse
    task automatic pulse(input logic [3:0] ch, input logic [7:0] val);
        @(posedge clock);
        sample_valid   <= 1'b1;
        sample_channel <= ch;
        sample_value   <= val;
        @(posedge clock);
        sample_valid   <= 1'b0;
    endtask

    // Main sequence
    initial begin
        void'($urandom(32'h6bde));
        {wb_cyc_i, wb_stb_i, wb_we_i, sample_valid} = 4'h0;
        wb_adr_i = 6'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        sample_channel = 4'h0;
        sample_value = 8'h00;
        supply_code_cpu0 = SUPPLY_CODE_W'($urandom);
        supply_code_cpu1 = SUPPLY_CODE_W'($urandom);
        failures = 0;
        checks_done = 0;
        cycles = 0;
        rst = 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        foreach (rst_tab[i]) rst_tab[i] = 8'h00;
        rst_tab[IDX_SUPPLY] = {3'b000, supply_code_cpu0};
        rst_tab[IDX_CH_HIGH] = RST_HIGH;
        for (int i = 0; i < 16; i++) wb_read(4'(i), rst_tab[i]);
        @(negedge clock);
        check(32'({mgmt_irq, host_irq, alarm_out}), 32'h0);
        wb_write(IDX_IRQ_LO, 8'hff);
        wb_write(IDX_IRQ_HI, 8'hff);
        wb_read(IDX_IRQ_HI, 8'h07);
        // Each channel: low-limit hit, routing, clear sequence
        for (int ch = 0; ch < NUM_CH; ch++) begin
            ev = 11'h1 << ch;
            v = 8'($urandom_range(0, 127));
            wb_write(IDX_SMI_LO, (ch % 2 == 0) ? ev[7:0] : 8'h00);
            wb_write(IDX_SMI_HI, (ch % 2 == 0) ? {5'h0, ev[10:8]} : 8'h00);
            wb_write(IDX_BANK, 8'(ch));
            wb_write(IDX_CH_CFG, 8'h03);
            wb_write(IDX_CH_LOW, 8'h80);
            pulse(4'(ch), v);
            wb_read(IDX_CH_READ, v);
            wb_read(IDX_CH_CFG, 8'h23);
            @(negedge clock);
            check(32'(mgmt_irq), 32'(ch % 2 == 0));
            check(32'({host_irq, alarm_out}), 32'h3);
            wb_write(IDX_EVT_LO, 8'h00);
            wb_write(IDX_EVT_HI, 8'h00);
            wb_write(IDX_CH_CFG, 8'h63);
            wb_read(IDX_EVT_LO, ev[7:0]);
            wb_read(IDX_EVT_HI, {5'h0, ev[10:8]});
            wb_read(IDX_EVT_LO, 8'h00);
            wb_read(IDX_EVT_HI, 8'h00);
            @(negedge clock);
            check(32'({mgmt_irq, host_irq, alarm_out}), 32'h0);
        end
        check(32'(channel_enable_out), 32'h7ff);
        // Channel 10: high-limit hit, sticky status, status writes ignored
        wb_write(IDX_CH_HIGH, 8'h40);
        wb_read(IDX_CH_HIGH, 8'h40);
        v = 8'($urandom_range(129, 255));
        pulse(4'ha, v);
        wb_read(IDX_CH_CFG, 8'h43);
        wb_read(IDX_EVT_HI, 8'h04);
        wb_read(IDX_EVT_HI, 8'h04);
        @(negedge clock);
        check(32'(mgmt_irq), 32'h1);
        wb_write(IDX_CH_CFG, 8'h43);
        wb_read(IDX_EVT_HI, 8'h04);
        wb_write(IDX_EVT_HI, 8'hff);
        wb_write(IDX_EVT_LO, 8'hff);
        wb_read(IDX_EVT_HI, 8'h00);
        wb_read(IDX_EVT_LO, 8'h00);
        // Common registers, reserved bits and places
        wb_write(IDX_BANK, 8'hff);
        wb_read(IDX_BANK, 8'h0f);
        wb_read(IDX_CH_LOW, 8'h00);
        wb_write(IDX_SMI_HI, 8'hff);
        wb_read(IDX_SMI_HI, 8'h07);
        cf = 8'($urandom);
        wb_write(IDX_SMI_LO, cf);
        wb_read(IDX_SMI_LO, cf);
        wb_cycle(1'b1, IDX_SMI_LO, ~cf, 4'he);
        wb_read(IDX_SMI_LO, cf);
        wb_write(IDX_RATE, 8'hff);
        wb_read(IDX_RATE, 8'h3f);
        wb_write(IDX_CONFIG, cf);
        wb_read(IDX_CONFIG, cf);
        wb_write(4'hf, 8'hff);
        wb_read(4'hf, 8'h00);
        wb_write(IDX_SUPPLY, 8'h40);
        wb_read(IDX_SUPPLY, {3'b010, supply_code_cpu1});
        @(negedge clock);
        check(32'(conversion_rate_out), 32'h3f);
        check(32'(monitor_config_out), 32'(cf));
        repeat (4) @(posedge clock);
        check(32'(exp_q.size()), 32'h0);
        print_verdict();
    end
endmodule
